// *** rtl/swp_sleep_wake.sv ***
// status, sleep/wake and pin control logic of the link retimer
`timescale 1ns/1ps
module swp_sleep_wake (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // core status and sleep control
  input wire logic i_core_stable,
  input wire logic i_sleep_req,
  output logic o_cable_present_out,
  output logic o_oscillator_enable_out,
  // host uart
  input wire logic i_uart_active,
  input wire logic i_uart_tx_data,
  input wire logic i_host_uart_rx,
  output logic o_level_shift_enable_out,
  output logic o_host_uart_tx,
  output logic o_host_uart_tx_oe_n,
  // reference clock mode
  input wire logic i_refclk_input_select,
  output logic o_refclk_diff_mode,
  output logic o_refclk_neg_float,
  // auxiliary outputs
  input wire logic [1:0] i_aux_gpio_mode,
  input wire logic [1:0] i_aux_open_drain,
  input wire logic [1:0] i_aux_uart_tx,
  input wire logic [1:0] i_aux_gpio_value,
  output logic o_aux_uart_tx_a,
  output logic o_aux_uart_tx_a_oe_n,
  output logic o_aux_uart_tx_b,
  output logic o_aux_uart_tx_b_oe_n,
  // i2c controller
  input wire logic i_i2c_scl_run,
  input wire logic i_i2c_scl_in,
  input wire logic i_i2c_sda_pull_low,
  input wire logic i_i2c_sda_in,
  output logic o_i2c_scl_out,
  output logic o_i2c_scl_oe_n,
  output logic o_i2c_sda_out,
  output logic o_i2c_sda_oe_n,
  output logic o_i2c_sda_rx,
  // eeprom write enable
  input wire logic i_eeprom_writing,
  output logic o_eeprom_write_enable_out,
  output logic o_eeprom_write_enable_oe_n
);
  logic [swp_pkg::STABLE_CNT_W-1:0] stable_cnt_reg;
  logic [swp_pkg::STABLE_CNT_W-1:0] stable_cnt_next;
  logic stable_done;
  logic cable_next;
  logic wake_pend_reg;
  logic wake_clr;
  logic level_shift_enable_out_next;
  logic tx_next;
  swp_pkg::swp_scl_state_type scl_state_reg;
  swp_pkg::swp_scl_state_type scl_state_next;
  logic [swp_pkg::SCL_CNT_W-1:0] scl_cnt_reg;
  logic [swp_pkg::SCL_CNT_W-1:0] scl_cnt_next;
  logic scl_half_done;
  logic scl_stretch;

  // power-up settle counter and cable-present
  assign stable_done = (stable_cnt_reg == swp_pkg::STABLE_LAST);
  assign stable_cnt_next = stable_done ? stable_cnt_reg :
                           swp_pkg::STABLE_CNT_W'(stable_cnt_reg + 1'h1);
  assign cable_next = stable_done & i_core_stable;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stable_cnt_reg <= swp_pkg::STABLE_CNT_RST;
      o_cable_present_out <= swp_pkg::CABLE_RST;
    end else if (i_clk_en) begin
      stable_cnt_reg <= stable_cnt_next;
      o_cable_present_out <= cable_next;
    end
  end

  // wake latch armed only while asleep; runs off the receive edge itself
  assign wake_clr = i_sys_rst | o_oscillator_enable_out;

  always_ff @(negedge i_host_uart_rx or posedge wake_clr) begin
    if (wake_clr) begin
      wake_pend_reg <= 1'h0;
    end else begin
      wake_pend_reg <= 1'h1;
    end
  end

  // oscillator enable doubles as the deep-sleep indicator
  always_ff @(posedge i_ref_clk or posedge i_sys_rst or posedge wake_pend_reg) begin
    if (i_sys_rst) begin
      o_oscillator_enable_out <= swp_pkg::OSC_EN_RST;
    end else if (wake_pend_reg) begin
      o_oscillator_enable_out <= 1'h1;
    end else if (i_clk_en && i_sleep_req) begin
      o_oscillator_enable_out <= 1'h0;
    end
  end

  // host uart level shift and tri-state transmit
  assign level_shift_enable_out_next = i_uart_active & o_oscillator_enable_out & ~i_sleep_req;
  assign tx_next = level_shift_enable_out_next ? i_uart_tx_data : swp_pkg::TX_RST;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_level_shift_enable_out <= swp_pkg::LEVEL_SHIFT_ENABLE_OUT_RST;
      o_host_uart_tx <= swp_pkg::TX_RST;
      o_host_uart_tx_oe_n <= swp_pkg::OE_N_RELEASE;
    end else if (i_clk_en) begin
      o_level_shift_enable_out <= level_shift_enable_out_next;
      o_host_uart_tx <= tx_next;
      o_host_uart_tx_oe_n <= ~level_shift_enable_out_next;
    end
  end

  // reference clock pin mode; reset value matches the pulled-down select
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_refclk_diff_mode <= swp_pkg::DIFF_RST;
      o_refclk_neg_float <= ~swp_pkg::DIFF_RST;
    end else if (i_clk_en) begin
      o_refclk_diff_mode <= i_refclk_input_select;
      o_refclk_neg_float <= ~i_refclk_input_select;
    end
  end

  // auxiliary outputs
  swp_aux_out u_aux_a (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_gpio_mode(i_aux_gpio_mode[0]),
    .i_open_drain(i_aux_open_drain[0]),
    .i_uart_tx(i_aux_uart_tx[0]),
    .i_gpio_value(i_aux_gpio_value[0]),
    .o_pin_out(o_aux_uart_tx_a),
    .o_pin_oe_n(o_aux_uart_tx_a_oe_n)
  );

  swp_aux_out u_aux_b (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_gpio_mode(i_aux_gpio_mode[1]),
    .i_open_drain(i_aux_open_drain[1]),
    .i_uart_tx(i_aux_uart_tx[1]),
    .i_gpio_value(i_aux_gpio_value[1]),
    .o_pin_out(o_aux_uart_tx_b),
    .o_pin_oe_n(o_aux_uart_tx_b_oe_n)
  );

  // i2c clock generator with stretch detect
  assign scl_half_done = (scl_cnt_reg == swp_pkg::SCL_HALF_LAST);
  assign scl_stretch = (scl_state_reg == swp_pkg::SCL_HIGH) & ~i_i2c_scl_in;

  always_comb begin
    scl_state_next = scl_state_reg;
    scl_cnt_next = swp_pkg::SCL_CNT_W'(scl_cnt_reg + 1'h1);
    unique case (scl_state_reg)
      swp_pkg::SCL_IDLE: begin
        scl_cnt_next = swp_pkg::SCL_CNT_RST;
        if (i_i2c_scl_run) begin
          scl_state_next = swp_pkg::SCL_LOW;
        end
      end
      swp_pkg::SCL_LOW: begin
        if (scl_half_done) begin
          scl_state_next = swp_pkg::SCL_HIGH;
          scl_cnt_next = swp_pkg::SCL_CNT_RST;
        end
      end
      swp_pkg::SCL_HIGH: begin
        if (scl_stretch) begin
          scl_cnt_next = swp_pkg::SCL_CNT_RST;
        end else if (scl_half_done) begin
          scl_state_next = i_i2c_scl_run ? swp_pkg::SCL_LOW : swp_pkg::SCL_IDLE;
          scl_cnt_next = swp_pkg::SCL_CNT_RST;
        end
      end
      default: begin
        scl_state_next = swp_pkg::SCL_IDLE;
        scl_cnt_next = swp_pkg::SCL_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_state_reg <= swp_pkg::SCL_IDLE;
      scl_cnt_reg <= swp_pkg::SCL_CNT_RST;
      o_i2c_scl_oe_n <= swp_pkg::OE_N_RELEASE;
    end else if (i_clk_en) begin
      scl_state_reg <= scl_state_next;
      scl_cnt_reg <= scl_cnt_next;
      o_i2c_scl_oe_n <= swp_pkg::swp_od_oe_n(scl_state_next == swp_pkg::SCL_LOW);
    end
  end

  // i2c data and eeprom write enable, both open-drain
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_i2c_scl_out <= swp_pkg::OD_LOW;
      o_i2c_sda_out <= swp_pkg::OD_LOW;
      o_i2c_sda_oe_n <= swp_pkg::OE_N_RELEASE;
      o_i2c_sda_rx <= 1'h1;
      o_eeprom_write_enable_out <= swp_pkg::OD_LOW;
      o_eeprom_write_enable_oe_n <= swp_pkg::OE_N_RELEASE;
    end else if (i_clk_en) begin
      o_i2c_scl_out <= swp_pkg::OD_LOW;
      o_i2c_sda_out <= swp_pkg::OD_LOW;
      o_i2c_sda_oe_n <= swp_pkg::swp_od_oe_n(i_i2c_sda_pull_low);
      o_i2c_sda_rx <= i_i2c_sda_in;
      o_eeprom_write_enable_out <= swp_pkg::OD_LOW;
      o_eeprom_write_enable_oe_n <= swp_pkg::swp_od_oe_n(i_eeprom_writing);
    end
  end

  // checks
  sequence s_sleep_asked;
    i_clk_en && i_sleep_req && o_oscillator_enable_out;
  endsequence

  sequence s_asleep_quiet;
    !o_oscillator_enable_out && i_host_uart_rx;
  endsequence

  a_cable_needs_stable: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_cable_present_out |-> stable_done && $past(i_core_stable))
    else $error("cable present before settle");
  a_osc_enter_sleep: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_sleep_asked |=> !o_oscillator_enable_out || !i_host_uart_rx)
    else $error("oscillator enable not low on sleep");
  a_osc_normal_high: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_oscillator_enable_out && !(i_clk_en && i_sleep_req) |=> o_oscillator_enable_out)
    else $error("oscillator enable dropped without sleep");
  a_osc_hold_low: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_asleep_quiet ##1 i_host_uart_rx |-> !o_oscillator_enable_out)
    else $error("woke without receive edge");
  a_wake_on_fall: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !o_oscillator_enable_out ##1 $fell(i_host_uart_rx) |-> o_oscillator_enable_out)
    else $error("receive fall did not wake");
  a_level_shift_enable_out_tx_float: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !o_level_shift_enable_out |-> o_host_uart_tx_oe_n)
    else $error("transmit driven with level shift off");
  a_idle_tx_float: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && !i_uart_active |=> o_host_uart_tx_oe_n && !o_level_shift_enable_out)
    else $error("unused uart still driven");
  a_level_shift_enable_out_active: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en && i_uart_active && !i_sleep_req && o_oscillator_enable_out
    |=> o_level_shift_enable_out && !o_host_uart_tx_oe_n)
    else $error("level shift not raised for active uart");
  a_refclk_mode: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en |=> o_refclk_diff_mode == $past(i_refclk_input_select)
                 && o_refclk_neg_float == !$past(i_refclk_input_select))
    else $error("refclk mode mismatch");
  a_scl_low_time: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (scl_state_reg == swp_pkg::SCL_LOW) |-> !o_i2c_scl_oe_n && !o_i2c_scl_out
                                           && scl_cnt_reg <= swp_pkg::SCL_HALF_LAST)
    else $error("scl low phase wrong");
  a_sda_open_drain: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en |=> !o_i2c_sda_out && o_i2c_sda_oe_n == !$past(i_i2c_sda_pull_low))
    else $error("sda drive wrong");
  a_eeprom_we_low: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_clk_en |=> o_eeprom_write_enable_oe_n == !$past(i_eeprom_writing))
    else $error("eeprom write enable wrong");
endmodule // swp_sleep_wake

// *** rtl/swp_pkg.sv ***
// constants, types and helpers shared by the sleep/wake status pin logic
package swp_pkg;
  // clock
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int CLK_PERIOD_NS = 10;
  // power-up settle time before the cable-present flag rises
  localparam int STABLE_TIME_NS = 1000;
  localparam int STABLE_CYCLES = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STABLE_CNT_W = 12;
  localparam logic [STABLE_CNT_W-1:0] STABLE_LAST = STABLE_CNT_W'(STABLE_CYCLES - 1);
  localparam logic [STABLE_CNT_W-1:0] STABLE_CNT_RST = 12'h000;
  // i2c clock
  localparam int I2C_RATE_HZ = 400000;
  localparam int I2C_HALF_CYCLES = CLK_FREQ_HZ / (2 * I2C_RATE_HZ);
  localparam int SCL_CNT_W = 7;
  localparam logic [SCL_CNT_W-1:0] SCL_HALF_LAST = SCL_CNT_W'(I2C_HALF_CYCLES - 1);
  localparam logic [SCL_CNT_W-1:0] SCL_CNT_RST = 7'h00;
  // reset values
  localparam logic OSC_EN_RST = 1'h1;
  localparam logic CABLE_RST = 1'h0;
  localparam logic LEVEL_SHIFT_ENABLE_OUT_RST = 1'h0;
  localparam logic TX_RST = 1'h1;
  localparam logic OE_N_RELEASE = 1'h1;
  localparam logic DIFF_RST = 1'h0;
  localparam logic OD_LOW = 1'h0;
  // scl generator states
  typedef enum logic [1:0] {
    SCL_IDLE = 2'h0,
    SCL_LOW = 2'h1,
    SCL_HIGH = 2'h3
  } swp_scl_state_type;
  // open-drain enable: low drives the pin low, high releases it
  function automatic logic swp_od_oe_n(input logic pull_low);
    return ~pull_low;
  endfunction
endpackage

// *** rtl/swp_aux_out.sv ***
// configurable auxiliary output cell: uart or gpio, push-pull or open-drain
`timescale 1ns/1ps
module swp_aux_out (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // configuration
  input wire logic i_gpio_mode,
  input wire logic i_open_drain,
  // data
  input wire logic i_uart_tx,
  input wire logic i_gpio_value,
  // pin
  output logic o_pin_out,
  output logic o_pin_oe_n
);
  logic pin_level;
  logic out_next;
  logic oe_n_next;

  assign pin_level = i_gpio_mode ? i_gpio_value : i_uart_tx;
  assign out_next = i_open_drain ? swp_pkg::OD_LOW : pin_level;
  assign oe_n_next = i_open_drain ? swp_pkg::swp_od_oe_n(~pin_level) : 1'h0;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin_out <= swp_pkg::TX_RST;
      o_pin_oe_n <= swp_pkg::OE_N_RELEASE;
    end else if (i_clk_en) begin
      o_pin_out <= out_next;
      o_pin_oe_n <= oe_n_next;
    end
  end

  a_aux_od_level: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $past(i_clk_en) && $past(i_open_drain) |-> !o_pin_out && (o_pin_oe_n == $past(pin_level)))
    else $error("open-drain aux pin drives high or wrong enable");
endmodule // swp_aux_out

// *** bench/swp_host_model.sv ***
// host-side partner: uart wake line and i2c wires with pull-ups
`timescale 1ns/1ps
module swp_host_model (
  // clock
  input wire logic i_ref_clk,
  // bench control
  input wire logic i_wake,
  input wire logic i_stretch,
  input wire logic i_sda_hold,
  // device pins
  input wire logic i_scl_oe_n,
  input wire logic i_sda_oe_n,
  output logic o_host_uart_rx,
  output logic o_scl_wire,
  output logic o_sda_wire
);
  logic sda_hold_reg = 1'h0;
  initial o_host_uart_rx = 1'h1;
  // idle high, one high-to-low step per wake request
  always @(posedge i_ref_clk) o_host_uart_rx <= ~i_wake;
  // pulled-up open-drain wires, host may hold the clock low
  assign o_scl_wire = i_scl_oe_n & ~i_stretch;
  // host pulls data low one cycle after the bench asks, like the device's own drive
  always @(posedge i_ref_clk) sda_hold_reg <= i_sda_hold;
  assign o_sda_wire = i_sda_oe_n & ~sda_hold_reg;
endmodule // swp_host_model

// *** bench/tb_swp_sleep_wake.sv ***
// self-checking testbench of the sleep/wake status pin logic
`timescale 1ns/1ps
module tb_swp_sleep_wake;
  typedef struct {int cyc; int id; logic val;} swp_exp_type;
  logic i_ref_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic clk_en, core_stable, sleep_req, uart_active, tx_data, sel, scl_run, sda_pull;
  logic ee_writing, wake, stretch, rx, scl_wire, sda_wire, sda_hold;
  logic [1:0] gm, od, ut, gv;
  logic [17:0] obs;
  logic ob0, ob1, ob2, ob3, ob4, ob5, ob6, ob7, ob8, ob9, ob10, ob11, ob12, ob13, ob14;
  logic ob15, ob16, ob17;
  swp_exp_type q[$];
  int cyc = 0;
  int fail_count = 0;
  int checked = 0;
  int seed;
  logic a, d, p, v, h;
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  swp_sleep_wake uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
    .i_core_stable(core_stable), .i_sleep_req(sleep_req), .o_cable_present_out(ob0),
    .o_oscillator_enable_out(ob1), .i_uart_active(uart_active), .i_uart_tx_data(tx_data),
    .i_host_uart_rx(rx), .o_level_shift_enable_out(ob2), .o_host_uart_tx(ob3),
    .o_host_uart_tx_oe_n(ob4), .i_refclk_input_select(sel), .o_refclk_diff_mode(ob5),
    .o_refclk_neg_float(ob6), .i_aux_gpio_mode(gm), .i_aux_open_drain(od),
    .i_aux_uart_tx(ut), .i_aux_gpio_value(gv), .o_aux_uart_tx_a(ob7),
    .o_aux_uart_tx_a_oe_n(ob8), .o_aux_uart_tx_b(ob9), .o_aux_uart_tx_b_oe_n(ob10),
    .i_i2c_scl_run(scl_run), .i_i2c_scl_in(scl_wire), .i_i2c_sda_pull_low(sda_pull),
    .i_i2c_sda_in(sda_wire), .o_i2c_scl_out(ob15), .o_i2c_scl_oe_n(ob11), .o_i2c_sda_out(ob16),
    .o_i2c_sda_oe_n(ob12), .o_i2c_sda_rx(ob13), .i_eeprom_writing(ee_writing),
    .o_eeprom_write_enable_out(ob17), .o_eeprom_write_enable_oe_n(ob14));
  swp_host_model host (.i_ref_clk(i_ref_clk), .i_wake(wake), .i_stretch(stretch),
    .i_sda_hold(sda_hold), .i_scl_oe_n(ob11), .i_sda_oe_n(ob12), .o_host_uart_rx(rx),
    .o_scl_wire(scl_wire), .o_sda_wire(sda_wire));
  assign obs = {ob17, ob16, ob15, ob14, ob13, ob12, ob11, ob10, ob9,
                ob8, ob7, ob6, ob5, ob4, ob3, ob2, ob1, ob0};
  // note a value due dly edges after the current one; cyc still reads the pre-edge count
  task automatic note(input int dly, input int id, input logic val);
    q.push_back('{cyc + dly + 1, id, val});
  endtask
  task automatic check(input int id, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH out%0d expected %b seen %b", id, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // monitor: take due notes off the queue and compare
  always @(negedge i_ref_clk) begin : mon
    int i;
    i = 0;
    while (i < q.size()) begin
      if (q[i].cyc == cyc) begin
        check(q[i].id, obs[q[i].id], q[i].val);
        q.delete(i);
      end else i++;
    end
  end
  initial begin
    repeat (3000) @(posedge i_ref_clk);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    seed = 52294;
    {clk_en, core_stable, sleep_req, uart_active, tx_data, sel, scl_run} <= 7'h60;
    {sda_pull, ee_writing, wake, stretch, gm, od, ut, gv} <= 12'h000;
    sda_hold <= 1'h0;
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    note(0, 0, 1'h0);
    note(0, 1, 1'h1);
    note(0, 4, 1'h1);
    note(0, 5, 1'h0);
    note(0, 14, 1'h1);
    note(99, 0, 1'h0);
    note(100, 0, 1'h1);
    repeat (101) @(posedge i_ref_clk);
    core_stable <= 1'h0;
    note(1, 0, 1'h0);
    @(posedge i_ref_clk);
    core_stable <= 1'h1;
    // uart, refclk, aux, sda and eeprom pins with random data
    for (int k = 0; k < 16; k++) begin
      a = 1'($random(seed));
      d = 1'($random(seed));
      p = 1'($random(seed));
      h = 1'($random(seed));
      uart_active <= a;
      tx_data <= d;
      sel <= p;
      sda_pull <= d;
      ee_writing <= p;
      sda_hold <= h;
      gm <= k[1:0];
      od <= k[3:2];
      ut <= 2'($random(seed));
      gv <= 2'($random(seed));
      @(posedge i_ref_clk);
      note(0, 1, 1'h1);
      note(0, 2, a);
      note(0, 4, ~a);
      note(0, 3, a ? d : 1'h1);
      note(0, 5, p);
      note(0, 6, ~p);
      note(0, 12, ~d);
      note(1, 13, ~d & ~h);
      note(0, 14, ~p);
      note(0, 15, 1'h0);
      note(0, 16, 1'h0);
      note(0, 17, 1'h0);
      for (int c = 0; c < 2; c++) begin
        v = gm[c] ? gv[c] : ut[c];
        note(0, 7 + 2 * c, od[c] ? 1'h0 : v);
        note(0, 8 + 2 * c, od[c] ? v : 1'h0);
      end
    end
    // deep sleep and wake with the clock held off
    uart_active <= 1'h1;
    sleep_req <= 1'h1;
    note(1, 1, 1'h0);
    note(1, 2, 1'h0);
    note(1, 4, 1'h1);
    note(20, 1, 1'h0);
    note(20, 2, 1'h0);
    @(posedge i_ref_clk);
    sleep_req <= 1'h0;
    repeat (20) @(posedge i_ref_clk);
    clk_en <= 1'h0;
    wake <= 1'h1;
    note(0, 1, 1'h0);
    note(1, 1, 1'h1);
    @(posedge i_ref_clk);
    wake <= 1'h0;
    repeat (3) @(posedge i_ref_clk);
    clk_en <= 1'h1;
    note(2, 2, 1'h1);
    note(2, 4, 1'h0);
    repeat (3) @(posedge i_ref_clk);
    // i2c clock halves of 125 cycles, stretched by the host
    scl_run <= 1'h1;
    note(0, 11, 1'h1);
    note(1, 11, 1'h0);
    note(125, 11, 1'h0);
    note(126, 11, 1'h1);
    note(320, 11, 1'h1);
    note(440, 11, 1'h1);
    note(454, 11, 1'h1);
    note(455, 11, 1'h0);
    note(470, 11, 1'h0);
    repeat (130) @(posedge i_ref_clk);
    stretch <= 1'h1;
    repeat (200) @(posedge i_ref_clk);
    stretch <= 1'h0;
    repeat (200) @(posedge i_ref_clk);
    scl_run <= 1'h0;
    repeat (5) @(posedge i_ref_clk);
    if (q.size() != 0) fail_count++;
    tally_and_finish;
  end
endmodule // tb_swp_sleep_wake
